/* File: core/fscr_pkg.sv */
package fscr_pkg;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned PTR_W     = 5;
  localparam int unsigned DEPTH     = 16;
  localparam int unsigned LVL_W     = 24;
  localparam int unsigned CSR_AW    = 3;
  localparam int unsigned ENT_W     = DATA_W + 3;
  // Build options: packet support and store-and-forward support
  localparam bit          OPT_PKT   = 1'b1;
  localparam bit          OPT_SF    = 1'b1;
  // Word offsets of the control and status port
  localparam logic [2:0]  OFS_OCC   = 3'h0;
  localparam logic [2:0]  OFS_RSVD  = 3'h1;
  localparam logic [2:0]  OFS_NFULL = 3'h2;
  localparam logic [2:0]  OFS_NEMPT = 3'h3;
  localparam logic [2:0]  OFS_FWD   = 3'h4;
  localparam logic [2:0]  OFS_DISC  = 3'h5;
  // Reset values, and the entry count at which the store is full
  localparam logic [23:0] RST_NFULL = 24'h00000F;
  localparam logic [23:0] RST_NEMPT = 24'h000000;
  localparam logic [23:0] RST_FWD   = 24'h000000;
  localparam logic        RST_DISC  = 1'b0;
  localparam logic [4:0]  FULL_CNT  = 5'h10;
  typedef enum logic [1:0] {FSCR_PLAIN, FSCR_STORE, FSCR_CUT} fscr_mode_t;
endpackage

/* File: core/fscr_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Word 0 reads fill count in low 24 bits, upper bits zero, resets zero.
// - Word 2 near-full limit, read/write, resets to depth minus one.
// - Word 3 near-empty limit, read/write, resets to zero.
// - Word 4 forward-start count; zero selects store-and-forward; resets zero.
// - Nonzero count: source valid held low until that many entries stored.
// - Once a packet starts leaving in cut-through, it runs to its end beat.
// - Forward-start count only matters when store-and-forward option is built.
// - Word 5 discard enable, resets off; needs packet and store-and-forward options and a zero forward-start count.
// - Word 1 is reserved and reads zero.
// - Write-side and read-side 24-bit occupancy values, zero after reset.
// - Near-full flag high while fill count is at or above its limit.
// - Near-empty flag high while fill count is at or below its limit.
// - Read-side occupancy counts output stage; write-side count excludes it.
module fscr_top
  import fscr_pkg::*;
(
  input  wire logic              CLOCK_I,
  input  wire logic              RST_N_I,
  input  wire logic [CSR_AW-1:0] CSR_ADDR_I,
  input  wire logic              CSR_READ_I,
  input  wire logic              CSR_WRITE_I,
  input  wire logic [31:0]       CSR_WDATA_I,
  output logic      [31:0]       CSR_RDATA_O,
  input  wire logic [DATA_W-1:0] SNK_DATA_I,
  input  wire logic              SNK_VALID_I,
  input  wire logic              SNK_SOP_I,
  input  wire logic              SNK_EOP_I,
  input  wire logic              SNK_ERR_I,
  output logic                   SNK_READY_O,
  output logic      [DATA_W-1:0] SRC_DATA_O,
  output logic                   SRC_VALID_O,
  output logic                   SRC_SOP_O,
  output logic                   SRC_EOP_O,
  output logic                   SRC_ERR_O,
  input  wire logic              SRC_READY_I,
  output logic                   NEAR_FULL_O,
  output logic                   NEAR_EMPTY_O,
  output logic      [LVL_W-1:0]  WR_SIDE_LEVEL_O,
  output logic      [LVL_W-1:0]  RD_SIDE_LEVEL_O
);

  function automatic logic [PTR_W-1:0] ptr_diff(input logic [PTR_W-1:0] a,
                                                input logic [PTR_W-1:0] b);
    ptr_diff = a - b;
  endfunction

  logic [ENT_W-1:0]  mem [DEPTH];
  logic [PTR_W-1:0]  wr_ptr;
  logic [PTR_W-1:0]  rd_ptr;
  logic [PTR_W-1:0]  cmt_ptr;
  logic              in_pkt;
  logic [LVL_W-1:0]  nfull_lim;
  logic [LVL_W-1:0]  nempt_lim;
  logic [LVL_W-1:0]  fwd_cnt;
  logic              discard;
  logic [ENT_W-1:0]  ob_head;
  logic [ENT_W-1:0]  ob_tail;
  logic [1:0]        ob_cnt;
  logic [LVL_W-1:0]  occ;
  logic [31:0]       rd_mux;

  fscr_mode_t        mode;
  logic [PTR_W-1:0]  fill;
  logic [PTR_W-1:0]  cmt_cnt;
  logic              cmt_ok;
  logic              acc;
  logic              drop_now;
  logic              can_pop;
  logic              push;
  logic              pop_out;
  logic [ENT_W-1:0]  rd_ent;
  logic [PTR_W-1:0]  next_wr;
  logic [PTR_W-1:0]  next_rd;
  logic [PTR_W-1:0]  next_cmt;
  logic [1:0]        next_ob_cnt;
  logic [LVL_W-1:0]  fill_x;
  logic [LVL_W-1:0]  total_x;
  logic              wr_en;
  logic              sel_occ;
  logic              sel_rsvd;
  logic              sel_nfull;
  logic              sel_nempt;
  logic              sel_fwd;
  logic              sel_disc;
  logic              wr_nfull;
  logic              wr_nempt;
  logic              wr_fwd;
  logic              wr_disc;
  logic              next_ready;
  logic              next_nfull_flag;
  logic              next_nempt_flag;

  // Mode selection
  assign mode = !OPT_SF          ? FSCR_PLAIN :
                (fwd_cnt == '0)  ? FSCR_STORE :
                                   FSCR_CUT;

  assign fill     = ptr_diff(wr_ptr, rd_ptr);
  assign cmt_cnt  = ptr_diff(cmt_ptr, rd_ptr);
  // Committed span is stale once cut-through reads have passed it
  assign cmt_ok   = cmt_cnt <= fill;
  assign fill_x   = {{(LVL_W-PTR_W){1'b0}}, fill};
  assign total_x  = fill_x + {{(LVL_W-2){1'b0}}, ob_cnt};

  assign acc      = SNK_VALID_I && SNK_READY_O;
  // Rollback only while the packet is still wholly unread
  assign drop_now = acc && SNK_EOP_I && SNK_ERR_I && discard && OPT_PKT && OPT_SF
                    && (mode == FSCR_STORE) && cmt_ok;
  assign next_wr  = drop_now ? cmt_ptr : (acc ? wr_ptr + 5'h01 : wr_ptr);
  assign next_cmt = (acc && SNK_EOP_I) ? next_wr : cmt_ptr;

  always_comb begin
    case (mode)
      FSCR_STORE: can_pop = cmt_ok && (cmt_cnt != '0);
      FSCR_CUT:   can_pop = (fill != '0) && (in_pkt || fill_x >= fwd_cnt);
      default:    can_pop = fill != '0;
    endcase
  end

  assign rd_ent      = mem[rd_ptr[PTR_W-2:0]];
  assign push        = can_pop && (ob_cnt != 2'h2);
  assign pop_out     = SRC_VALID_O && SRC_READY_I;
  assign next_rd     = push ? rd_ptr + 5'h01 : rd_ptr;
  assign next_ob_cnt = ob_cnt + {1'b0, push} - {1'b0, pop_out};
  assign wr_en       = CSR_WRITE_I;

  // Word selects feed the read mux; those of words 2 to 5 also feed the write enables
  assign sel_occ     = CSR_ADDR_I == OFS_OCC;
  assign sel_rsvd    = CSR_ADDR_I == OFS_RSVD;
  assign sel_nfull   = CSR_ADDR_I == OFS_NFULL;
  assign sel_nempt   = CSR_ADDR_I == OFS_NEMPT;
  assign sel_fwd     = CSR_ADDR_I == OFS_FWD;
  assign sel_disc    = CSR_ADDR_I == OFS_DISC;
  // Writes to words 0, 1, 6 and 7 fall through with no effect
  assign wr_nfull    = wr_en && sel_nfull;
  assign wr_nempt    = wr_en && sel_nempt;
  assign wr_fwd      = wr_en && sel_fwd;
  assign wr_disc     = wr_en && sel_disc;

  // Ready looks at next-cycle pointers so a full store is never overrun
  assign next_ready      = ptr_diff(next_wr, next_rd) < FULL_CNT;
  assign next_nfull_flag = total_x >= nfull_lim;
  assign next_nempt_flag = total_x <= nempt_lim;

  always_comb begin
    rd_mux = 32'h00000000;
    // Reserved and unmapped words read as zero
    if (sel_occ) begin
      rd_mux = {8'h00, occ};
    end else if (sel_rsvd) begin
      rd_mux = 32'h00000000;
    end else if (sel_nfull) begin
      rd_mux = {8'h00, nfull_lim};
    end else if (sel_nempt) begin
      rd_mux = {8'h00, nempt_lim};
    end else if (sel_fwd) begin
      rd_mux = {8'h00, fwd_cnt};
    end else if (sel_disc) begin
      rd_mux = {31'h00000000, discard};
    end
  end

  // Storage has no reset; contents are only read behind valid pointers
  always_ff @(posedge CLOCK_I) begin
    if (acc) begin
      mem[wr_ptr[PTR_W-2:0]] <= {SNK_SOP_I, SNK_EOP_I, SNK_ERR_I, SNK_DATA_I};
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      cmt_ptr     <= '0;
    end else begin
      wr_ptr      <= next_wr;
      rd_ptr      <= next_rd;
      cmt_ptr     <= next_cmt;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SNK_READY_O <= 1'b0;
    end else begin
      SNK_READY_O <= next_ready;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      in_pkt <= 1'b0;
    end else if (push && OPT_PKT) begin
      in_pkt <= !rd_ent[DATA_W+1];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      nfull_lim <= RST_NFULL;
    end else if (wr_nfull) begin
      nfull_lim <= CSR_WDATA_I[LVL_W-1:0];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      nempt_lim <= RST_NEMPT;
    end else if (wr_nempt) begin
      nempt_lim <= CSR_WDATA_I[LVL_W-1:0];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      fwd_cnt <= RST_FWD;
    end else if (wr_fwd) begin
      fwd_cnt <= CSR_WDATA_I[LVL_W-1:0];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      discard <= RST_DISC;
    end else if (wr_disc) begin
      discard <= CSR_WDATA_I[0];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CSR_RDATA_O <= 32'h00000000;
    end else if (CSR_READ_I) begin
      CSR_RDATA_O <= rd_mux;
    end
  end

  // Two-entry output stage; a stalled sink backs up into storage, not lost
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ob_head     <= '0;
      ob_tail     <= '0;
      ob_cnt      <= 2'h0;
      SRC_VALID_O <= 1'b0;
    end else begin
      ob_cnt      <= next_ob_cnt;
      SRC_VALID_O <= next_ob_cnt != 2'h0;
      if (pop_out) begin
        ob_head <= (push && ob_cnt == 2'h1) ? rd_ent : ob_tail;
        if (push && ob_cnt == 2'h2) begin
          ob_tail <= rd_ent;
        end
      end else if (push) begin
        if (ob_cnt == 2'h0) begin
          ob_head <= rd_ent;
        end else begin
          ob_tail <= rd_ent;
        end
      end
    end
  end

  assign SRC_DATA_O = ob_head[DATA_W-1:0];
  assign SRC_ERR_O  = ob_head[DATA_W];
  assign SRC_EOP_O  = ob_head[DATA_W+1];
  assign SRC_SOP_O  = ob_head[DATA_W+2];

  // Status lags the pointers by one cycle
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      occ <= '0;
    end else begin
      occ <= total_x;
    end
  end

  // Flags reset to what an empty store gives against the reset limits
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      NEAR_FULL_O <= 1'b0;
    end else begin
      NEAR_FULL_O <= next_nfull_flag;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      NEAR_EMPTY_O <= 1'b1;
    end else begin
      NEAR_EMPTY_O <= next_nempt_flag;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      WR_SIDE_LEVEL_O <= '0;
      RD_SIDE_LEVEL_O <= '0;
    end else begin
      WR_SIDE_LEVEL_O <= fill_x;
      RD_SIDE_LEVEL_O <= total_x;
    end
  end

endmodule // fscr_top

/* File: dv/fscr_sink_mdl.sv */
`timescale 1ns/1ps
module fscr_sink_mdl (
  input  wire logic        clk_i,
  input  wire logic        rst_ni,
  input  wire logic        valid_i,
  input  wire logic [31:0] data_i,
  input  wire logic        sop_i,
  input  wire logic        eop_i,
  input  wire logic        err_i,
  input  wire logic        stall_i,
  output logic             ready_o
);
  logic [31:0] got[$];
  logic [2:0]  flg[$];
  // Ready moves only after an edge, like registered downstream logic
  always @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      ready_o <= 1'b0;
    end else begin
      if (valid_i && ready_o) begin
        got.push_back(data_i);
        flg.push_back({sop_i, eop_i, err_i});
      end
      ready_o <= !stall_i;
    end
  end
endmodule // fscr_sink_mdl

/* File: dv/fscr_chk.sv */
`timescale 1ns/1ps
module fscr_chk
  import fscr_pkg::*;
(
  input logic        CLOCK_I,
  input logic        RST_N_I,
  input logic [2:0]  CSR_ADDR_I,
  input logic        CSR_READ_I,
  input logic        CSR_WRITE_I,
  input logic [31:0] CSR_WDATA_I,
  input logic [31:0] CSR_RDATA_O,
  input logic        SRC_VALID_O,
  input logic        SRC_READY_I,
  input logic        NEAR_FULL_O,
  input logic        NEAR_EMPTY_O,
  input logic [23:0] WR_SIDE_LEVEL_O,
  input logic [23:0] RD_SIDE_LEVEL_O
);
  logic [23:0] nf;
  logic [23:0] ne;
  logic [23:0] fw;
  logic        dc;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      nf <= RST_NFULL;
      ne <= RST_NEMPT;
      fw <= RST_FWD;
      dc <= RST_DISC;
    end else if (CSR_WRITE_I) begin
      if (CSR_ADDR_I == OFS_NFULL) nf <= CSR_WDATA_I[23:0];
      if (CSR_ADDR_I == OFS_NEMPT) ne <= CSR_WDATA_I[23:0];
      if (CSR_ADDR_I == OFS_FWD) fw <= CSR_WDATA_I[23:0];
      if (CSR_ADDR_I == OFS_DISC) dc <= CSR_WDATA_I[0];
    end
  end
  property rdp(a, v);
    CSR_READ_I && CSR_ADDR_I == a |=> CSR_RDATA_O == v;
  endproperty
  a_occ_read: assert property (rdp(OFS_OCC, {8'h00, $past(RD_SIDE_LEVEL_O)}))
    else $error("bad occupancy read");
  a_rsvd_zero: assert property (rdp(OFS_RSVD, 32'h0))
    else $error("bad reserved read");
  a_nfull_read: assert property (rdp(OFS_NFULL, {8'h00, $past(nf)}))
    else $error("bad near-full limit read");
  a_nempty_read: assert property (rdp(OFS_NEMPT, {8'h00, $past(ne)}))
    else $error("bad near-empty limit read");
  a_disc_bits: assert property (rdp(OFS_DISC, {31'h00000000, $past(dc)}))
    else $error("bad discard read");
  a_fwd_read: assert property (rdp(OFS_FWD, {8'h00, $past(fw)}))
    else $error("bad forward-start read");
  // A limit write lands one cycle before the flag can follow it
  a_full_flag: assert property (!$past(CSR_WRITE_I) |-> NEAR_FULL_O == (RD_SIDE_LEVEL_O >= nf))
    else $error("bad near-full flag");
  a_empty_flag: assert property (!$past(CSR_WRITE_I) |-> NEAR_EMPTY_O == (RD_SIDE_LEVEL_O <= ne))
    else $error("bad near-empty flag");
  a_side_gap: assert property (RD_SIDE_LEVEL_O >= WR_SIDE_LEVEL_O &&
    RD_SIDE_LEVEL_O - WR_SIDE_LEVEL_O <= 24'h2) else $error("bad level gap");
  cover property (SRC_VALID_O && !SRC_READY_I);
  cover property (NEAR_FULL_O);
  cover property (CSR_READ_I && CSR_ADDR_I == OFS_FWD);
endmodule // fscr_chk
bind fscr_top fscr_chk u_chk (.*);

/* File: dv/fscr_tb.sv */
`timescale 1ns/1ps
module testbench
  import fscr_pkg::*;
;
  logic CLOCK_I, RST_N_I, CSR_READ_I, CSR_WRITE_I, SNK_VALID_I, SNK_SOP_I, SNK_EOP_I;
  logic SNK_ERR_I, SNK_READY_O, SRC_VALID_O, SRC_SOP_O, SRC_EOP_O, SRC_ERR_O, SRC_READY_I;
  logic NEAR_FULL_O, NEAR_EMPTY_O, stall;
  logic [2:0] CSR_ADDR_I;
  logic [31:0] CSR_WDATA_I, CSR_RDATA_O, SNK_DATA_I, SRC_DATA_O;
  logic [23:0] WR_SIDE_LEVEL_O, RD_SIDE_LEVEL_O;
  int mismatches, num_checks;
  fscr_top DUT (.*);
  fscr_sink_mdl u_mdl (.clk_i(CLOCK_I), .rst_ni(RST_N_I), .valid_i(SRC_VALID_O),
    .data_i(SRC_DATA_O), .sop_i(SRC_SOP_O), .eop_i(SRC_EOP_O), .err_i(SRC_ERR_O),
    .stall_i(stall), .ready_o(SRC_READY_I));
  task automatic chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic nap(input int n);
    repeat (n) @(negedge CLOCK_I);
  endtask
  // Strobes are rewritten every call so back-to-back accesses need no gap
  task automatic csr(input logic w, r, input logic [2:0] a, input logic [31:0] d);
    CSR_WRITE_I <= w;
    CSR_READ_I <= r;
    CSR_ADDR_I <= a;
    CSR_WDATA_I <= d;
    nap(1);
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    csr(0, 1, a, 0);
    chk(CSR_RDATA_O, e);
  endtask
  task automatic snd(input logic [31:0] d, input logic s, e, r);
    SNK_VALID_I <= 1;
    SNK_DATA_I <= d;
    SNK_SOP_I <= s;
    SNK_EOP_I <= e;
    SNK_ERR_I <= r;
    // Ready is registered: its level now is what the next edge samples
    while (!SNK_READY_O) nap(1);
    nap(1);
  endtask
  task automatic conclude();
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    CLOCK_I = 0;
    forever #12.5 CLOCK_I = ~CLOCK_I;
  end
  initial begin
    repeat (3000) @(posedge CLOCK_I);
    mismatches++;
    conclude();
  end
  initial begin
    {RST_N_I, CSR_READ_I, CSR_WRITE_I, SNK_VALID_I, SNK_SOP_I, SNK_EOP_I, SNK_ERR_I} = 0;
    {CSR_ADDR_I, CSR_WDATA_I, SNK_DATA_I, stall} = 0;
    nap(5);
    RST_N_I = 1;
    csr(1, 0, OFS_OCC, 32'hFF);
    rd(OFS_OCC, 0);
    rd(OFS_RSVD, 0);
    rd(OFS_NFULL, 32'h0F);
    rd(OFS_NEMPT, 0);
    rd(OFS_FWD, 0);
    rd(OFS_DISC, 0);
    csr(1, 0, OFS_NFULL, 32'h3);
    csr(1, 0, OFS_NEMPT, 32'h1);
    rd(OFS_NFULL, 32'h3);
    rd(OFS_NEMPT, 32'h1);
    snd(32'h10, 1, 0, 0);
    snd(32'h11, 0, 0, 0);
    SNK_VALID_I <= 0;
    nap(10);
    chk(32'(u_mdl.got.size()), 0);
    // Discard still off, so a bad packet goes through whole
    snd(32'h12, 0, 1, 1);
    SNK_VALID_I <= 0;
    nap(10);
    chk(u_mdl.got[2], 32'h12);
    chk(32'(u_mdl.flg[0]), 32'h4);
    chk(32'(u_mdl.flg[2]), 32'h3);
    csr(1, 0, OFS_DISC, 32'h1);
    rd(OFS_DISC, 1);
    for (int i = 0; i < 4; i++) snd(32'h20 + i, i == 0, i == 3, i == 3);
    SNK_VALID_I <= 0;
    nap(12);
    chk(32'(u_mdl.got.size()), 3);
    rd(OFS_OCC, 0);
    csr(1, 0, OFS_FWD, 32'h3);
    rd(OFS_FWD, 32'h3);
    snd(32'h30, 1, 0, 0);
    snd(32'h31, 0, 0, 0);
    SNK_VALID_I <= 0;
    nap(10);
    chk(32'(u_mdl.got.size()), 3);
    snd(32'h32, 0, 0, 0);
    SNK_VALID_I <= 0;
    nap(10);
    chk(32'(u_mdl.got.size()), 6);
    // Lone end beat sits below the threshold yet must still leave
    snd(32'h33, 0, 1, 0);
    SNK_VALID_I <= 0;
    nap(10);
    chk(u_mdl.got[6], 32'h33);
    chk(32'(u_mdl.flg[6]), 32'h2);
    stall = 1;
    for (int i = 0; i < 18; i++) snd(32'h40 + i, i == 0, 0, 0);
    SNK_VALID_I <= 0;
    nap(4);
    chk(32'(RD_SIDE_LEVEL_O), 18);
    chk(32'(WR_SIDE_LEVEL_O), 16);
    rd(OFS_OCC, 18);
    stall = 0;
    snd(32'h52, 0, 1, 0);
    SNK_VALID_I <= 0;
    nap(40);
    for (int i = 0; i < 19; i++) chk(u_mdl.got[7 + i], 32'h40 + i);
    chk(32'(u_mdl.got.size()), 26);
    chk(32'(u_mdl.flg[7]), 32'h4);
    chk(32'(u_mdl.flg[25]), 32'h2);
    conclude();
  end
endmodule // testbench
